// ### rtl/tcrr_regs.vh
// constants for the telecommand response reporter
`ifndef TCRR_REGS_VH
`define TCRR_REGS_VH
// register offsets (byte addresses)
`define TCRR_ADR_CTRL 8'h00
`define TCRR_ADR_MODE 8'h04
`define TCRR_ADR_BEDS 8'h08
`define TCRR_ADR_DEVS 8'h0C
`define TCRR_ADR_IRQ_STAT 8'h10
`define TCRR_ADR_IRQ_MASK 8'h14
`define TCRR_ADR_COUNT 8'h18
// control fields and reset values
`define TCRR_CTRL_ACC_BIT 0
`define TCRR_CTRL_START_BIT 1
`define TCRR_CTRL_COMPL_BIT 2
`define TCRR_CTRL_RST 3'h7
`define TCRR_BEDS_RST 16'h0000
`define TCRR_DEVS_RST 8'h00
`define TCRR_MODE_RST 4'h0
// interrupt status bits
`define TCRR_IRQ_FAIL_BIT 0
`define TCRR_IRQ_DONE_BIT 1
`define TCRR_IRQ_MODE_BIT 2
// telecommand services and subtypes
`define TCRR_SVC_VERIFY 8'h01
`define TCRR_SVC_HK 8'h03
`define TCRR_SVC_EVENT 8'h05
`define TCRR_SVC_FUNC 8'h08
`define TCRR_SVC_TIME 8'h09
`define TCRR_SVC_FWD 8'h0E
`define TCRR_SVC_TEST 8'h11
`define TCRR_ST_ACCEPT 8'h01
`define TCRR_ST_FAIL 8'h02
`define TCRR_ST_START 8'h03
`define TCRR_ST_COMPL 8'h07
`define TCRR_ST_FUNC 8'h04
`define TCRR_ST_TIME_SET 8'h04
`define TCRR_ST_TIME_RATE 8'h05
`define TCRR_ST_TIME_REQ 8'h07
`define TCRR_ST_TIME_REP 8'h09
`define TCRR_ST_FWD_EN 8'h01
`define TCRR_ST_FWD_DIS 8'h02
`define TCRR_ST_FWD_REQ 8'h03
`define TCRR_ST_FWD_REP 8'h04
`define TCRR_ST_CONN_REQ 8'h01
`define TCRR_ST_CONN_REP 8'h02
`define TCRR_ST_EVT_MODE 8'h01
// function identifiers
`define TCRR_FID_BOOT 16'h00C8
`define TCRR_FID_INIT 16'h00D2
`define TCRR_FID_HMON 16'h00DC
`define TCRR_FID_HCHK 16'h00E6
`define TCRR_FID_REGEN 16'h00F0
`define TCRR_FID_STARTUP 16'h00FA
`define TCRR_FID_DEFROST 16'h0104
`define TCRR_FID_NORMAL 16'h010E
`define TCRR_FID_SHUTDOWN 16'h0118
`define TCRR_FID_BEDPOS 16'h012D
`define TCRR_FID_BEDRST 16'h0136
`define TCRR_FID_BEDSET 16'h0191
`define TCRR_FID_DEVSET 16'h01F5
`define TCRR_FID_STOP 16'h0258
// operating mode codes
`define TCRR_MODE_BOOT 4'h0
`define TCRR_MODE_INIT 4'h1
`define TCRR_MODE_HMON 4'h2
`define TCRR_MODE_HCHK 4'h3
`define TCRR_MODE_REGEN 4'h4
`define TCRR_MODE_STARTUP 4'h5
`define TCRR_MODE_DEFROST 4'h6
`define TCRR_MODE_NORMAL 4'h7
`define TCRR_MODE_SHUTDOWN 4'h8
// failure codes
`define TCRR_FAIL_ILLEGAL 16'h0005
`define TCRR_FAIL_UNKNOWN 16'h0001
`endif

// ### rtl/tcrr_reporter.v
// telecommand response reporter with wishbone registers
`timescale 1ns/10ps
`default_nettype none
`include "tcrr_regs.vh"
module tcrr_reporter #(
  parameter BED_STATE_MAX = 8'h07,
  parameter DEV_COUNT = 4'h8
) (
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // telecommand input
  input wire cmd_valid_i,
  input wire [7:0] cmd_service_i,
  input wire [7:0] cmd_subtype_i,
  input wire [15:0] cmd_func_i,
  input wire [15:0] cmd_arg_i,
  input wire cmd_mode_ok_i,
  input wire cmd_exec_ok_i,
  output reg cmd_ready_o,
  // telemetry report output
  output reg rep_valid_o,
  output reg [7:0] rep_service_o,
  output reg [7:0] rep_subtype_o,
  output reg [15:0] rep_code_o,
  input wire rep_ready_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // interrupt
  output reg irq_o
);

  localparam S_IDLE = 2'h0;
  localparam S_SEND = 2'h1;
  localparam S_WAIT = 2'h2;

  localparam K_NONE = 3'h0;
  localparam K_MODE = 3'h1;
  localparam K_COMPL = 3'h2;
  localparam K_TIME = 3'h3;
  localparam K_FWD = 3'h4;
  localparam K_CONN = 3'h5;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg pend_fail_q;
  reg pend_acc_q;
  reg pend_start_q;
  reg pend_follow_q;
  reg [2:0] kind_q;
  reg [15:0] fail_code_q;
  reg [3:0] new_mode_q;
  reg [2:0] ctrl_q;
  reg [3:0] mode_q;
  reg [15:0] beds_q;
  reg [7:0] devs_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg [7:0] ok_cnt_q;
  reg [7:0] fail_cnt_q;

  // decode of the incoming telecommand
  reg known;
  reg is_mode;
  reg [3:0] dec_mode;
  reg param_ok;
  reg [2:0] dec_kind;
  reg is_func;
  always @*
  begin
    known = 1'b1;
    is_mode = 1'b0;
    dec_mode = `TCRR_MODE_BOOT;
    param_ok = cmd_exec_ok_i;
    dec_kind = K_NONE;
    is_func = (cmd_service_i == `TCRR_SVC_FUNC) &&
      (cmd_subtype_i == `TCRR_ST_FUNC);
    if (is_func)
    begin
      case (cmd_func_i)
        `TCRR_FID_BOOT: dec_mode = `TCRR_MODE_BOOT;
        `TCRR_FID_INIT: dec_mode = `TCRR_MODE_INIT;
        `TCRR_FID_HMON: dec_mode = `TCRR_MODE_HMON;
        `TCRR_FID_HCHK: dec_mode = `TCRR_MODE_HCHK;
        `TCRR_FID_REGEN: dec_mode = `TCRR_MODE_REGEN;
        `TCRR_FID_STARTUP: dec_mode = `TCRR_MODE_STARTUP;
        `TCRR_FID_DEFROST: dec_mode = `TCRR_MODE_DEFROST;
        `TCRR_FID_NORMAL: dec_mode = `TCRR_MODE_NORMAL;
        `TCRR_FID_SHUTDOWN: dec_mode = `TCRR_MODE_SHUTDOWN;
        default: dec_mode = `TCRR_MODE_BOOT;
      endcase
      case (cmd_func_i)
        `TCRR_FID_BOOT, `TCRR_FID_INIT, `TCRR_FID_HMON, `TCRR_FID_HCHK,
        `TCRR_FID_REGEN, `TCRR_FID_STARTUP, `TCRR_FID_DEFROST,
        `TCRR_FID_NORMAL, `TCRR_FID_SHUTDOWN:
        begin
          is_mode = 1'b1;
          dec_kind = K_MODE;
        end
        `TCRR_FID_BEDPOS: param_ok = cmd_exec_ok_i;
        `TCRR_FID_BEDRST: param_ok = 1'b1;
        `TCRR_FID_BEDSET:
          // bed index in arg[15:8] (0 lower, 1 upper), state in arg[7:0]
          param_ok = cmd_exec_ok_i && (cmd_arg_i[15:9] == 7'h00) &&
            (cmd_arg_i[7:0] <= BED_STATE_MAX);
        `TCRR_FID_DEVSET:
          // device index in arg[11:8], state in arg[0]
          param_ok = cmd_exec_ok_i && (cmd_arg_i[15:12] == 4'h0) &&
            (cmd_arg_i[11:8] < DEV_COUNT);
        `TCRR_FID_STOP: param_ok = cmd_exec_ok_i;
        default: known = 1'b0;
      endcase
    end
    else
    begin
      case ({cmd_service_i, cmd_subtype_i})
        {`TCRR_SVC_TIME, `TCRR_ST_TIME_SET},
        {`TCRR_SVC_TIME, `TCRR_ST_TIME_RATE},
        {`TCRR_SVC_FWD, `TCRR_ST_FWD_EN},
        {`TCRR_SVC_FWD, `TCRR_ST_FWD_DIS}: dec_kind = K_COMPL;
        {`TCRR_SVC_TIME, `TCRR_ST_TIME_REQ}: dec_kind = K_TIME;
        {`TCRR_SVC_FWD, `TCRR_ST_FWD_REQ}: dec_kind = K_FWD;
        {`TCRR_SVC_TEST, `TCRR_ST_CONN_REQ}: dec_kind = K_CONN;
        default: known = 1'b0;
      endcase
    end
  end

  // command pass or fail
  wire cmd_ok = known && cmd_mode_ok_i && param_ok;
  // taken only while ready shows, so never in the cycle after reset
  wire cmd_take = cmd_ready_o && cmd_valid_i;
  wire rep_done = rep_valid_o && rep_ready_i;
  wire any_pend = pend_fail_q | pend_acc_q | pend_start_q | pend_follow_q;

  // report sequencer
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (cmd_take) state_d = S_SEND;
      S_SEND: state_d = any_pend ? S_WAIT : S_IDLE;
      S_WAIT: if (rep_done) state_d = S_SEND;
      default: state_d = S_IDLE;
    endcase
  end

  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      state_q <= S_IDLE;
      pend_fail_q <= 1'b0;
      pend_acc_q <= 1'b0;
      pend_start_q <= 1'b0;
      pend_follow_q <= 1'b0;
      kind_q <= K_NONE;
      fail_code_q <= 16'h0000;
      new_mode_q <= `TCRR_MODE_RST;
      cmd_ready_o <= 1'b0;
      rep_valid_o <= 1'b0;
      rep_service_o <= 8'h00;
      rep_subtype_o <= 8'h00;
      rep_code_o <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      cmd_ready_o <= (state_d == S_IDLE);
      if (cmd_take)
      begin
        kind_q <= dec_kind;
        new_mode_q <= dec_mode;
        // unknown commands carry their own failure code
        fail_code_q <= known ? `TCRR_FAIL_ILLEGAL : `TCRR_FAIL_UNKNOWN;
        // a failure suppresses every success and data report
        pend_fail_q <= !cmd_ok;
        pend_acc_q <= cmd_ok && ctrl_q[`TCRR_CTRL_ACC_BIT];
        pend_start_q <= cmd_ok && ctrl_q[`TCRR_CTRL_START_BIT];
        pend_follow_q <= cmd_ok && (dec_kind != K_NONE) &&
          ((dec_kind != K_COMPL) || ctrl_q[`TCRR_CTRL_COMPL_BIT]);
      end
      if (rep_done)
        rep_valid_o <= 1'b0;
      if (state_q == S_SEND)
      begin
        rep_valid_o <= any_pend;
        if (pend_fail_q)
        begin
          pend_fail_q <= 1'b0;
          rep_service_o <= `TCRR_SVC_VERIFY;
          rep_subtype_o <= `TCRR_ST_FAIL;
          rep_code_o <= fail_code_q;
        end
        else if (pend_acc_q)
        begin
          pend_acc_q <= 1'b0;
          rep_service_o <= `TCRR_SVC_VERIFY;
          rep_subtype_o <= `TCRR_ST_ACCEPT;
          rep_code_o <= 16'h0000;
        end
        else if (pend_start_q)
        begin
          pend_start_q <= 1'b0;
          rep_service_o <= `TCRR_SVC_VERIFY;
          rep_subtype_o <= `TCRR_ST_START;
          rep_code_o <= 16'h0000;
        end
        else if (pend_follow_q)
        begin
          pend_follow_q <= 1'b0;
          rep_code_o <= 16'h0000;
          case (kind_q)
            K_MODE:
            begin
              rep_service_o <= `TCRR_SVC_EVENT;
              rep_subtype_o <= `TCRR_ST_EVT_MODE;
              rep_code_o <= {12'h000, new_mode_q};
            end
            K_TIME:
            begin
              rep_service_o <= `TCRR_SVC_TIME;
              rep_subtype_o <= `TCRR_ST_TIME_REP;
            end
            K_FWD:
            begin
              rep_service_o <= `TCRR_SVC_FWD;
              rep_subtype_o <= `TCRR_ST_FWD_REP;
            end
            K_CONN:
            begin
              rep_service_o <= `TCRR_SVC_TEST;
              rep_subtype_o <= `TCRR_ST_CONN_REP;
            end
            default:
            begin
              rep_service_o <= `TCRR_SVC_VERIFY;
              rep_subtype_o <= `TCRR_ST_COMPL;
            end
          endcase
        end
      end
    end
  end

  // success side effects on housekeeping state
  wire take_ok = cmd_take && cmd_ok;
  wire take_fail = cmd_take && !cmd_ok;
  wire [3:0] dev_idx = cmd_arg_i[11:8];
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      mode_q <= `TCRR_MODE_RST;
      beds_q <= `TCRR_BEDS_RST;
      devs_q <= `TCRR_DEVS_RST;
    end
    else if (take_ok && is_func)
    begin
      if (is_mode)
        mode_q <= dec_mode;
      case (cmd_func_i)
        `TCRR_FID_BEDPOS: beds_q <= cmd_arg_i;
        `TCRR_FID_BEDRST: beds_q <= `TCRR_BEDS_RST;
        `TCRR_FID_BEDSET:
          if (cmd_arg_i[8])
            beds_q[15:8] <= cmd_arg_i[7:0];
          else
            beds_q[7:0] <= cmd_arg_i[7:0];
        `TCRR_FID_DEVSET: devs_q[dev_idx[2:0]] <= cmd_arg_i[0];
        default: beds_q <= beds_q;
      endcase
    end
  end

  // wishbone slave, one wait state, unmapped reads return zero
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge at which the master sees ack
  wire wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o &&
    wb_we_i && wb_sel_i[0];
  wire stat_rd = wb_req && !wb_we_i && (wb_adr_i == `TCRR_ADR_IRQ_STAT);
  wire [2:0] irq_ev;
  assign irq_ev[`TCRR_IRQ_FAIL_BIT] = take_fail;
  assign irq_ev[`TCRR_IRQ_DONE_BIT] = take_ok;
  assign irq_ev[`TCRR_IRQ_MODE_BIT] = take_ok && is_mode;
  wire [2:0] irq_stat_d = (stat_rd ? 3'h0 : irq_stat_q) | irq_ev;

  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_q <= `TCRR_CTRL_RST;
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      irq_o <= 1'b0;
      ok_cnt_q <= 8'h00;
      fail_cnt_q <= 8'h00;
    end
    else
    begin
      wb_ack_o <= wb_req;
      irq_stat_q <= irq_stat_d;
      irq_o <= |(irq_stat_d & irq_mask_q);
      if (take_ok)
        ok_cnt_q <= ok_cnt_q + 8'h01;
      if (take_fail)
        fail_cnt_q <= fail_cnt_q + 8'h01;
      if (wb_wr)
      begin
        case (wb_adr_i)
          `TCRR_ADR_CTRL: ctrl_q <= wb_dat_i[2:0];
          `TCRR_ADR_IRQ_MASK: irq_mask_q <= wb_dat_i[2:0];
          default: ctrl_q <= ctrl_q;
        endcase
      end
      if (wb_req)
      begin
        case (wb_adr_i)
          `TCRR_ADR_CTRL: wb_dat_o <= {29'h0, ctrl_q};
          `TCRR_ADR_MODE: wb_dat_o <= {28'h0, mode_q};
          `TCRR_ADR_BEDS: wb_dat_o <= {16'h0, beds_q};
          `TCRR_ADR_DEVS: wb_dat_o <= {24'h0, devs_q};
          `TCRR_ADR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_q};
          `TCRR_ADR_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_q};
          `TCRR_ADR_COUNT: wb_dat_o <= {16'h0, fail_cnt_q, ok_cnt_q};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // tcrr_reporter
`default_nettype wire

// ### tb/tcrr_ground_sink.sv
// ground side telemetry sink with random stalls
`timescale 1ns/10ps
`default_nettype none
module tcrr_ground_sink (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // report acceptance
  output logic rep_ready_o
);
  initial rep_ready_o = 1'b0;
  always @(posedge clk_sys_i)
    rep_ready_o <= resetn_i && ($urandom % 3 != 0);
endmodule // tcrr_ground_sink
`default_nettype wire

// ### tb/tcrr_reporter_bench.sv
// testbench for the telecommand response reporter
`timescale 1ns/10ps
`default_nettype none
module tcrr_reporter_bench;
  logic clk_sys_i = 0, resetn_i = 0, cmd_valid_i = 0;
  logic [7:0] cmd_service_i = 0, cmd_subtype_i = 0, wb_adr_i = 0;
  logic [15:0] cmd_func_i = 0, cmd_arg_i = 0;
  logic cmd_mode_ok_i = 0, cmd_exec_ok_i = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, rd;
  wire cmd_ready_o, rep_valid_o, rep_ready_i, wb_ack_o, irq_o;
  wire [7:0] rep_service_o, rep_subtype_o;
  wire [15:0] rep_code_o;
  wire [31:0] wb_dat_o;
  int err_total = 0, checks_done = 0, i;
  logic [31:0] exp_q[$];
  logic [2:0] ctrl_m = 3'h7;
  logic [3:0] mode_m = 4'h0;
  logic [15:0] beds_m = 16'h0000, tbl[4];
  logic [7:0] devs_m = 8'h00;
  logic sel0 = 1;
  int ok_m = 0, fail_m = 0;
  tcrr_reporter #(.BED_STATE_MAX(8'h07), .DEV_COUNT(4'h8)) dut_u (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
    .cmd_service_i(cmd_service_i), .cmd_subtype_i(cmd_subtype_i),
    .cmd_func_i(cmd_func_i), .cmd_arg_i(cmd_arg_i),
    .cmd_mode_ok_i(cmd_mode_ok_i), .cmd_exec_ok_i(cmd_exec_ok_i),
    .cmd_ready_o(cmd_ready_o), .rep_valid_o(rep_valid_o),
    .rep_service_o(rep_service_o), .rep_subtype_o(rep_subtype_o),
    .rep_code_o(rep_code_o), .rep_ready_i(rep_ready_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o));
  tcrr_ground_sink sink_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .rep_ready_o(rep_ready_i));
  initial forever #4 clk_sys_i = ~clk_sys_i;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks_done++;
    if (seen !== ex)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // reports compared in order against the model
  always @(negedge clk_sys_i)
    if (rep_valid_o === 1'b1 && rep_ready_i === 1'b1)
      chk("report", {rep_service_o, rep_subtype_o, rep_code_o},
        exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF);
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w;
    wb_adr_i <= a; wb_sel_i <= {3'($urandom), sel0}; wb_dat_i <= d;
    do begin @(posedge clk_sys_i); n++; end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    rd = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
    @(posedge clk_sys_i);
  endtask
  task cmd(input logic [7:0] s, u, input logic [15:0] f, a,
    input logic mo, eo);
    int n;
    logic fl, kn, md;
    n = 0;
    cmd_valid_i <= 1; cmd_service_i <= s; cmd_subtype_i <= u;
    cmd_func_i <= f; cmd_arg_i <= a; cmd_mode_ok_i <= mo; cmd_exec_ok_i <= eo;
    do begin @(posedge clk_sys_i); n++; end
    while (cmd_ready_o !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    cmd_valid_i <= 0;
    md = s == 8'h08 && u == 8'h04 && f >= 16'h00C8 && f <= 16'h0118
      && (f - 16'h00C8) % 16'h000A == 0;
    kn = md || (s == 8'h08 && u == 8'h04 && (f == 16'h012D || f == 16'h0136
      || f == 16'h0191 || f == 16'h01F5 || f == 16'h0258))
      || {s, u} == 16'h0904 || {s, u} == 16'h0905 || {s, u} == 16'h0907
      || {s, u} == 16'h0E01 || {s, u} == 16'h0E02 || {s, u} == 16'h0E03
      || {s, u} == 16'h1101;
    fl = !mo || (!eo && !(s == 8'h08 && f == 16'h0136))
      || (s == 8'h08 && f == 16'h0191 && (a[15:8] > 8'h01 || a[7:0] > 8'h07))
      || (s == 8'h08 && f == 16'h01F5 && a[15:8] > 8'h07);
    if (!kn || fl)
    begin
      fail_m++;
      exp_q.push_back(kn ? 32'h01020005 : 32'h01020001);
    end
    else
    begin
      ok_m++;
      if (ctrl_m[0]) exp_q.push_back(32'h01010000);
      if (ctrl_m[1]) exp_q.push_back(32'h01030000);
      if (md)
      begin
        mode_m = 4'((f - 16'h00C8) / 16'h000A);
        exp_q.push_back({16'h0501, 12'h000, mode_m});
      end
      if (s == 8'h08 && f == 16'h012D) beds_m = a;
      if (s == 8'h08 && f == 16'h0191 && a[8]) beds_m[15:8] = a[7:0];
      if (s == 8'h08 && f == 16'h0191 && !a[8]) beds_m[7:0] = a[7:0];
      if (s == 8'h08 && f == 16'h01F5) devs_m[a[10:8]] = a[0];
      if (ctrl_m[2] && (s == 8'h09 && (u == 8'h04 || u == 8'h05)
        || s == 8'h0E && (u == 8'h01 || u == 8'h02)))
        exp_q.push_back(32'h01070000);
      if ({s, u} == 16'h0907) exp_q.push_back(32'h09090000);
      if ({s, u} == 16'h0E03) exp_q.push_back(32'h0E040000);
      if ({s, u} == 16'h1101) exp_q.push_back(32'h11020000);
    end
    repeat (3) @(posedge clk_sys_i);
    n = 0;
    while ((exp_q.size() != 0 || cmd_ready_o !== 1'b1) && n < 400)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 400) err_total++;
    wb(0, 8'h04, 0); chk("mode", rd, {28'h0, mode_m});
    wb(0, 8'h08, 0); chk("beds", rd, {16'h0, beds_m});
    wb(0, 8'h0C, 0); chk("devs", rd, {24'h0, devs_m});
  endtask
  initial
  begin
    #400000;
    err_total++;
    conclude();
  end
  initial
  begin
    void'($urandom(32854));
    tbl = '{16'h0904, 16'h0905, 16'h0E01, 16'h0E02};
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1;
    @(posedge clk_sys_i);
    wb(0, 8'h00, 0); chk("ctrl", rd, 32'h7);
    sel0 = 0; wb(1, 8'h00, 32'h0); sel0 = 1;
    wb(0, 8'h00, 0); chk("ctrl sel", rd, 32'h7);
    wb(0, 8'h14, 0); chk("mask", rd, 32'h0);
    wb(1, 8'h1C, 32'h5); wb(0, 8'h1C, 0); chk("unmapped", rd, 32'h0);
    wb(1, 8'h14, 32'h1); wb(0, 8'h10, 0);
    cmd(8'h08, 8'h04, 16'h010E, 16'h0, 0, 1);
    chk("irq", {31'h0, irq_o}, 32'h1);
    wb(0, 8'h10, 0); chk("stat", rd, 32'h1);
    cmd(8'h08, 8'h04, 16'h010E, 16'h0, 1, 1);
    cmd(8'h08, 8'h04, 16'h0118, 16'h0, 1, 1);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    cmd(8'h08, 8'h04, 16'h012D, 16'($urandom), 1, 1);
    cmd(8'h08, 8'h04, 16'h012D, 16'h1234, 1, 0);
    cmd(8'h08, 8'h04, 16'h012D, 16'h1234, 0, 1);
    cmd(8'h08, 8'h04, 16'h0136, 16'h0, 0, 1);
    for (i = 0; i < 4; i++)
      cmd(8'h08, 8'h04, 16'h0191, {7'h0, 1'($urandom), 5'h0, 3'($urandom)},
        1, 1);
    cmd(8'h08, 8'h04, 16'h0191, 16'h0203, 1, 1);
    cmd(8'h08, 8'h04, 16'h0191, 16'h0108, 1, 1);
    cmd(8'h08, 8'h04, 16'h0191, 16'h0101, 0, 1);
    for (i = 0; i < 3; i++)
      cmd(8'h08, 8'h04, 16'h01F5, {5'h0, 3'($urandom), 7'h0, 1'($urandom)},
        1, 1);
    cmd(8'h08, 8'h04, 16'h01F5, 16'h0801, 1, 1);
    cmd(8'h08, 8'h04, 16'h01F5, 16'h0101, 0, 1);
    cmd(8'h08, 8'h04, 16'h0258, 16'h0, 1, 1);
    cmd(8'h08, 8'h04, 16'h0258, 16'h0, 1, 0);
    for (i = 0; i < 4; i++)
    begin
      cmd(tbl[i][15:8], tbl[i][7:0], 16'h0, 16'h0, 1, 1);
      cmd(tbl[i][15:8], tbl[i][7:0], 16'h0, 16'h0, 1, 0);
    end
    cmd(8'h09, 8'h07, 16'h0, 16'h0, 1, 1);
    cmd(8'h09, 8'h07, 16'h0, 16'h0, 1, 0);
    cmd(8'h0E, 8'h03, 16'h0, 16'h0, 1, 1);
    cmd(8'h0E, 8'h03, 16'h0, 16'h0, 0, 1);
    cmd(8'h11, 8'h01, 16'h0, 16'h0, 1, 1);
    cmd(8'h11, 8'h01, 16'h0, 16'h0, 1, 0);
    wb(1, 8'h00, {29'($urandom), 3'h1}); ctrl_m = 3'h1;
    cmd(8'h09, 8'h04, 16'h0, 16'h0, 1, 1);
    cmd(8'h11, 8'h01, 16'h0, 16'h0, 1, 1);
    wb(1, 8'h00, 32'h6); ctrl_m = 3'h6;
    cmd(8'h0E, 8'h01, 16'h0, 16'h0, 1, 1);
    wb(1, 8'h00, 32'h0); ctrl_m = 3'h0;
    cmd(8'h08, 8'h04, 16'h0258, 16'h0, 1, 1);
    wb(1, 8'h00, {29'($urandom), 3'h7}); ctrl_m = 3'h7;
    for (i = 0; i < 3; i++)
      cmd(8'h08, 8'h04, 16'h0258, 16'($urandom), 1'($urandom),
        1'($urandom));
    cmd(8'h08, 8'h04, 16'h00C9, 16'h0, 1, 1);
    cmd(8'h12, 8'($urandom), 16'($urandom), 16'h0, 1, 1);
    wb(0, 8'h18, 0); chk("count", rd, {16'h0, fail_m[7:0], ok_m[7:0]});
    conclude();
  end
endmodule // tcrr_reporter_bench
`default_nettype wire

// ### tb/tcrr_reporter_sva.sv
// assertions for the telecommand response reporter
`timescale 1ns/10ps
`default_nettype none
module tcrr_reporter_sva #(
  parameter BED_STATE_MAX = 8'h07,
  parameter DEV_COUNT = 4'h8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // command and report
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic rep_valid_o,
  input wire logic [7:0] rep_service_o,
  input wire logic [7:0] rep_subtype_o,
  input wire logic [15:0] rep_code_o,
  input wire logic rep_ready_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wire take = cmd_valid_i && cmd_ready_o;
  wire hs = rep_valid_o && rep_ready_i;
  wire is_fail = rep_service_o == 8'h01 && rep_subtype_o == 8'h02;
  logic fail_q, fail_d, ok_q, ok_d;
  // failure or success already sent for the current command
  always @*
  begin
    fail_d = take ? 1'b0 : (hs && is_fail) ? 1'b1 : fail_q;
    ok_d = take ? 1'b0 : (hs && !is_fail) ? 1'b1 : ok_q;
  end
  always @(posedge clk_sys_i)
  begin
    fail_q <= resetn_i ? fail_d : 1'b0;
    ok_q <= resetn_i ? ok_d : 1'b0;
  end
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_rep_holds: assert property (rep_valid_o && !rep_ready_i |=> rep_valid_o
    && $stable(rep_service_o) && $stable(rep_subtype_o) && $stable(rep_code_o))
    else $error("report changed before accepted");
  a_rep_gap: assert property (hs |=> !rep_valid_o)
    else $error("no idle cycle between reports");
  a_take_quiet: assert property (take |=> !rep_valid_o)
    else $error("report too early after command");
  a_fail_code: assert property (rep_valid_o && is_fail |->
    rep_code_o == 16'h0005 || rep_code_o == 16'h0001)
    else $error("bad failure code");
  a_no_data_after: assert property (rep_valid_o |-> !fail_q)
    else $error("report after failure");
  a_fail_alone: assert property (rep_valid_o && is_fail |-> !ok_q)
    else $error("failure after success report");
  a_mode_event: assert property (rep_valid_o && rep_service_o == 8'h05 |->
    rep_subtype_o == 8'h01 && rep_code_o <= 16'h0008)
    else $error("bad mode event");
  a_ready_idle: assert property (cmd_ready_o |-> !rep_valid_o)
    else $error("report while idle");
  c_fail: cover property (hs && is_fail);
  c_mode: cover property (hs && rep_service_o == 8'h05);
  c_conn: cover property (hs && rep_service_o == 8'h11);
endmodule // tcrr_reporter_sva
bind tcrr_reporter tcrr_reporter_sva #(.BED_STATE_MAX(BED_STATE_MAX),
  .DEV_COUNT(DEV_COUNT)) chk_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
  .rep_valid_o(rep_valid_o), .rep_service_o(rep_service_o),
  .rep_subtype_o(rep_subtype_o), .rep_code_o(rep_code_o),
  .rep_ready_i(rep_ready_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o));
`default_nettype wire
